// File: verilog/erx_pkg.sv
// package: extended read register layout, commands, failure-report encodings
package erx_pkg;
    localparam logic [7:0] ERX_OP_SET_NV    = 8'h85; // set_ext_params_nonvolatile
    localparam logic [7:0] ERX_OP_SET_V     = 8'h83; // set_ext_params_volatile
    localparam logic [7:0] ERX_OP_CLEAR     = 8'h82; // clear_ext_flags_cmd, code arbitrary here
    localparam int         ERX_DS_HI        = 7;     // drive strength field top bit
    localparam int         ERX_DS_LO        = 5;     // drive strength field low bit
    localparam int         ERX_LPE_BIT      = 4;     // learning_pattern_enable
    localparam int         ERX_EERR_BIT     = 3;     // erase error flag
    localparam int         ERX_PERR_BIT     = 2;     // program error flag
    localparam int         ERX_PROT_BIT     = 1;     // protect_violation_flag
    localparam int         ERX_RSV_BIT      = 0;     // reserved, always reads zero
    localparam logic [7:0] ERX_WR_MASK      = 8'hf0; // bits a set command may change
    localparam logic [2:0] ERX_DS_DEFAULT   = 3'h7;  // 50 percent
    localparam logic [2:0] ERX_DS_RSV_A     = 3'h0;  // reserved code
    localparam logic [2:0] ERX_DS_RSV_B     = 3'h4;  // reserved code
    localparam logic [7:0] ERX_RESET_VALUE  = 8'he0; // default image
    // class of the operation that just terminated
    typedef enum logic [3:0] {
        ERX_OP_NONE     = 4'h0,
        ERX_OP_PROGRAM  = 4'h1, // page, persistent bit, password program
        ERX_OP_INFO_PGM = 4'h2, // info row program
        ERX_OP_MODE_PGM = 4'h3, // protection mode lock bits program
        ERX_OP_UNLOCK   = 4'h4, // password unlock
        ERX_OP_NV_REG   = 4'h5, // non-volatile register update (erase then program)
        ERX_OP_STAT_WR  = 4'h6, // status register write
        ERX_OP_ERASE    = 4'h7, // sector/block/info/persistent erase
        ERX_OP_CHIP_ERS = 4'h8, // chip erase
        ERX_OP_FUNC_WR  = 4'h9  // function register write
    } erx_op_t;
endpackage

// File: verilog/erx_evt_if.sv
// interface: error events from the classifier to the register core
`timescale 1ns/1ps
interface erx_evt_if;
    logic set_prot; // raise protection flag
    logic set_perr; // raise program flag
    logic set_eerr; // raise erase flag
    modport src (output set_prot, output set_perr, output set_eerr);
    modport dst (input set_prot, input set_perr, input set_eerr);
endinterface

// File: verilog/erx_classify.sv
// module: maps a terminated operation and its outcome to error flag events
`timescale 1ns/1ps
module erx_classify (
    input  wire logic             done,         // operation terminated this cycle
    input  wire erx_pkg::erx_op_t op_kind,      // class of operation
    input  wire logic             target_prot,  // target sector/block/row protected or locked
    input  wire logic             target_susp,  // target sector suspended for erase
    input  wire logic             bp_covered,   // some block guarded by block_protect_field
    input  wire logic             fail_pgm,     // program portion failed
    input  wire logic             fail_ers,     // erase portion failed
    input  wire logic             mode_chosen,  // protection mode already selected
    input  wire logic [1:0]       mode_bits,    // lock bits being programmed
    input  wire logic             pwd_mismatch, // unlock password differs
    input  wire logic             swp_active,   // status_write_protect_bit with pin low
    erx_evt_if.src                evt
);
    // pure decode; read-only or otp data bits never reach here so raise nothing (see [R16] [R17])
    always_comb
    begin
        evt.set_prot = 1'b0;
        evt.set_perr = 1'b0;
        evt.set_eerr = 1'b0;
        if (done)
        begin
            unique case (op_kind)
                erx_pkg::ERX_OP_PROGRAM:
                begin
                    evt.set_perr = fail_pgm | target_prot | target_susp; // see [R6] [R20]
                    evt.set_prot = target_prot | target_susp;             // see [R8]
                end
                erx_pkg::ERX_OP_INFO_PGM:
                begin
                    evt.set_perr = fail_pgm | target_prot; // see [R9]
                    evt.set_prot = target_prot;            // see [R5]
                end
                erx_pkg::ERX_OP_MODE_PGM:
                begin
                    evt.set_prot = mode_chosen | (mode_bits == 2'h0);         // see [R10]
                    evt.set_perr = fail_pgm | evt.set_prot;
                end
                erx_pkg::ERX_OP_UNLOCK:
                begin
                    evt.set_prot = pwd_mismatch; // see [R11]
                    evt.set_perr = pwd_mismatch;
                end
                erx_pkg::ERX_OP_NV_REG:
                begin
                    evt.set_eerr = fail_ers; // see [R12]
                    evt.set_perr = fail_pgm;
                end
                erx_pkg::ERX_OP_STAT_WR:
                begin
                    evt.set_prot = swp_active;            // see [R13]
                    evt.set_eerr = swp_active | fail_ers;
                    evt.set_perr = fail_pgm;
                end
                erx_pkg::ERX_OP_ERASE:
                begin
                    evt.set_eerr = fail_ers | target_prot; // see [R7] [R14]
                    evt.set_prot = target_prot;
                end
                erx_pkg::ERX_OP_CHIP_ERS:
                begin
                    // sector lock bits alone do not flag a chip erase
                    evt.set_eerr = fail_ers | bp_covered; // see [R15]
                    evt.set_prot = bp_covered;
                end
                erx_pkg::ERX_OP_FUNC_WR:
                    evt.set_perr = fail_pgm; // see [R20]
                default:
                    ;
            endcase
        end
    end
endmodule

// File: verilog/erx_core.sv
// module: extended read control/status register with sticky error flags
`timescale 1ns/1ps
// Contract
// [R1] bits 7:5 select output drive strength
// [R2] error bits read-only, set commands skip them
// [R3] 85h writes non-volatile, 83h volatile copy
// [R4] bit 0 reserved, reads zero
// [R5] protection flag on protected region access
// [R6] program flag on program failure
// [R7] erase flag on erase failure
// [R8] protected program sets program and protection
// [R9] locked info row program sets both
// [R10] bad mode lock program sets both
// [R11] password mismatch sets program and protection
// [R12] nv update flags failing erase/program portion
// [R13] protected status write sets protection, erase
// [R14] failed/protected erase flags erase, protection
// [R15] chip erase flags only block-protect coverage
// [R16] otp zero writes ignored, no error
// [R17] read-only or frozen bits ignored silently
// [R18] flags sticky until clear or reset
// [R19] commands still execute with flags set
// [R20] program/function write failure sets program flag
// [R21] flags update when operation terminates
module erx_core (
    input  wire logic             clock,          // 10 MHz system clock
    input  wire logic             rstn,           // async hardware reset, active low
    input  wire logic             soft_reset,     // software reset pulse
    input  wire logic             cmd_valid,      // decoded register command pulse
    input  wire logic [7:0]       cmd_opcode,     // command opcode
    input  wire logic [7:0]       cmd_data,       // data byte of a set command
    input  wire logic             nv_done,        // non-volatile program of image finished ok
    input  wire logic             op_done,        // an array/register operation terminated
    input  wire erx_pkg::erx_op_t op_kind,        // its class
    input  wire logic             target_prot,    // target protected or locked
    input  wire logic             target_susp,    // target suspended for erase
    input  wire logic             bp_covered,     // block_protect_field covers a block
    input  wire logic             fail_pgm,       // program portion failed
    input  wire logic             fail_ers,       // erase portion failed
    input  wire logic             mode_chosen,    // protection mode already selected
    input  wire logic [1:0]       mode_bits,      // lock bits being programmed
    input  wire logic             pwd_mismatch,   // unlock password mismatch
    input  wire logic             swp_active,     // status write protect in force
    output logic [7:0]            reg_rdata,      // current register image
    output logic [7:0]            nv_image,       // non-volatile copy for the array
    output logic                  nv_write_req,   // pulse: program nv image
    output logic [2:0]            drive_strength, // active drive strength code
    output logic                  drive_reserved, // code is a reserved one
    output logic                  learning_pattern_enable // learning pattern on
);
    // whole state in one struct
    typedef struct packed {
        logic [2:0] ds;     // drive strength
        logic       lpe;    // learning pattern enable
        logic       eerr;   // erase error flag
        logic       perr;   // program error flag
        logic       prot;   // protection error flag
        logic [7:0] nv;     // non-volatile copy
        logic       nv_req; // nv program request
    } erx_state_t;

    erx_state_t st_r;   // registered state
    erx_state_t st_nxt; // next state
    erx_evt_if  evt (); // flag events

    // operation outcome decode
    erx_classify u_cls (
        .done         (op_done),
        .op_kind      (op_kind),
        .target_prot  (target_prot),
        .target_susp  (target_susp),
        .bp_covered   (bp_covered),
        .fail_pgm     (fail_pgm),
        .fail_ers     (fail_ers),
        .mode_chosen  (mode_chosen),
        .mode_bits    (mode_bits),
        .pwd_mismatch (pwd_mismatch),
        .swp_active   (swp_active),
        .evt          (evt)
    );

    // true when a 3-bit drive code is a reserved one
    function automatic logic ds_reserved(input logic [2:0] code);
        ds_reserved = (code == erx_pkg::ERX_DS_RSV_A) || (code == erx_pkg::ERX_DS_RSV_B);
    endfunction

    wire logic is_set_v  = cmd_valid && (cmd_opcode == erx_pkg::ERX_OP_SET_V);
    wire logic is_set_nv = cmd_valid && (cmd_opcode == erx_pkg::ERX_OP_SET_NV);
    wire logic is_clear  = cmd_valid && (cmd_opcode == erx_pkg::ERX_OP_CLEAR);

    // next state: writes, clears and sticky sets
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.nv_req = 1'b0;
        if (is_set_v || is_set_nv)
        begin
            // only writable bits taken; flags and bit 0 ignored (see [R2] [R3] [R17])
            st_nxt.ds  = cmd_data[erx_pkg::ERX_DS_HI:erx_pkg::ERX_DS_LO];
            st_nxt.lpe = cmd_data[erx_pkg::ERX_LPE_BIT];
        end
        if (is_set_nv)
        begin
            // nv copy keeps only writable bits, array update follows (see [R3] [R12])
            st_nxt.nv     = cmd_data & erx_pkg::ERX_WR_MASK;
            st_nxt.nv_req = 1'b1;
        end
        if (is_clear || soft_reset)
        begin
            st_nxt.eerr = 1'b0; // see [R18]
            st_nxt.perr = 1'b0;
            st_nxt.prot = 1'b0;
        end
        // set wins over a clear in the same cycle; no command is blocked (see [R19] [R21])
        if (evt.set_eerr)
            st_nxt.eerr = 1'b1; // see [R7] [R18]
        if (evt.set_perr)
            st_nxt.perr = 1'b1; // see [R6]
        if (evt.set_prot)
            st_nxt.prot = 1'b1; // see [R5]
        if (soft_reset)
        begin
            // software reset reloads volatile copy from nv copy
            st_nxt.ds  = st_r.nv[erx_pkg::ERX_DS_HI:erx_pkg::ERX_DS_LO];
            st_nxt.lpe = st_r.nv[erx_pkg::ERX_LPE_BIT];
        end
    end

    // state register; reset loads default image
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r        <= '0;
            st_r.ds     <= erx_pkg::ERX_DS_DEFAULT; // see [R1]
            st_r.nv     <= erx_pkg::ERX_RESET_VALUE;
        end
        else
            st_r <= st_nxt;
    end

    // outputs
    always_comb
    begin
        reg_rdata                         = '0; // bit 0 stays zero, see [R4]
        reg_rdata[erx_pkg::ERX_DS_HI:erx_pkg::ERX_DS_LO] = st_r.ds;
        reg_rdata[erx_pkg::ERX_LPE_BIT]   = st_r.lpe;
        reg_rdata[erx_pkg::ERX_EERR_BIT]  = st_r.eerr;
        reg_rdata[erx_pkg::ERX_PERR_BIT]  = st_r.perr;
        reg_rdata[erx_pkg::ERX_PROT_BIT]  = st_r.prot;
    end
    assign nv_image                = st_r.nv;
    assign nv_write_req            = st_r.nv_req;
    assign drive_strength          = st_r.ds;                // see [R1]
    assign drive_reserved          = ds_reserved(st_r.ds);   // see [R1]
    assign learning_pattern_enable = st_r.lpe;

    // nv_done only acknowledges the array program; the image is final
    // when nv_write_req rises, so nothing here waits on it

    // flag bits in register order, for the checks below
    wire logic [2:0] flag_bits = {st_r.eerr, st_r.perr, st_r.prot};

    // every check runs on the one clock and sleeps in reset
    default clocking chk_clk @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // reserved bit never reads one
    chk_bit0_zero: assert property ( // see [R4]
        reg_rdata[erx_pkg::ERX_RSV_BIT] == 1'b0)
        else $error("bit 0 not zero");

    // set commands never touch the flags
    chk_set_keeps_flags: assert property ( // see [R2] [R17]
        (is_set_v || is_set_nv) && !op_done && !soft_reset
        |=> flag_bits == $past(flag_bits))
        else $error("set command changed flags");

    // both set commands load drive code and pattern enable
    chk_set_applies: assert property ( // see [R3]
        (is_set_v || is_set_nv) && !soft_reset
        |=> {st_r.ds, st_r.lpe} == $past(cmd_data[erx_pkg::ERX_DS_HI:erx_pkg::ERX_LPE_BIT]))
        else $error("set data not applied");

    // nv copy keeps writable bits only
    chk_nv_copy: assert property ( // see [R3]
        is_set_nv
        |=> nv_write_req && nv_image == ($past(cmd_data) & erx_pkg::ERX_WR_MASK))
        else $error("nv copy wrong");

    // program request lasts one cycle
    chk_nv_req_pulse: assert property ( // see [R3]
        nv_write_req && !is_set_nv
        |=> !nv_write_req)
        else $error("nv request held");

    // read image shows the active drive code
    chk_ds_output: assert property ( // see [R1]
        reg_rdata[erx_pkg::ERX_DS_HI:erx_pkg::ERX_DS_LO] == drive_strength)
        else $error("drive code mismatch");

    // only the two reserved codes are marked
    chk_ds_reserved: assert property ( // see [R1]
        drive_reserved == (drive_strength == erx_pkg::ERX_DS_RSV_A
                           || drive_strength == erx_pkg::ERX_DS_RSV_B))
        else $error("reserved decode wrong");

    // read image shows the pattern enable
    chk_lpe_output: assert property ( // see [R3]
        reg_rdata[erx_pkg::ERX_LPE_BIT] == learning_pattern_enable)
        else $error("pattern enable mismatch");

    // read image shows the flags in place
    chk_flags_map: assert property ( // see [R2]
        reg_rdata[erx_pkg::ERX_EERR_BIT:erx_pkg::ERX_PROT_BIT] == flag_bits)
        else $error("flag bits misplaced");

    // no flag falls without clear or reset
    chk_flag_sticky: assert property ( // see [R18]
        !is_clear && !soft_reset
        |=> (flag_bits & $past(flag_bits)) == $past(flag_bits))
        else $error("flag dropped");

    // clear command or soft reset empties the flags
    chk_clear_flags: assert property ( // see [R18]
        (is_clear || soft_reset) && !op_done
        |=> flag_bits == 3'h0)
        else $error("clear failed");

    // flags move only on an operation end, a clear or a soft reset
    chk_flags_on_end: assert property ( // see [R21]
        !op_done && !is_clear && !soft_reset
        |=> flag_bits == $past(flag_bits))
        else $error("flags moved without an outcome");

    // a set still lands while flags stand
    chk_cmds_accepted: assert property ( // see [R19]
        is_set_v && (|flag_bits) && !soft_reset
        |=> st_r.ds == $past(cmd_data[erx_pkg::ERX_DS_HI:erx_pkg::ERX_DS_LO]))
        else $error("command blocked by flags");

    // protected or suspended program target
    chk_program_prot: assert property ( // see [R8]
        op_done && op_kind == erx_pkg::ERX_OP_PROGRAM && (target_prot || target_susp)
        |=> st_r.perr && st_r.prot)
        else $error("protected program unflagged");

    // failed program
    chk_program_fail: assert property ( // see [R6] [R20]
        op_done && op_kind == erx_pkg::ERX_OP_PROGRAM && fail_pgm
        |=> st_r.perr)
        else $error("program failure unflagged");

    // locked info row program
    chk_info_locked: assert property ( // see [R9] [R5]
        op_done && op_kind == erx_pkg::ERX_OP_INFO_PGM && target_prot
        |=> st_r.perr && st_r.prot)
        else $error("locked row program unflagged");

    // mode lock bits programmed late or both zero
    chk_mode_bad: assert property ( // see [R10]
        op_done && op_kind == erx_pkg::ERX_OP_MODE_PGM && (mode_chosen || mode_bits == 2'h0)
        |=> st_r.perr && st_r.prot)
        else $error("bad mode program unflagged");

    // wrong password on unlock
    chk_unlock_sets: assert property ( // see [R11]
        op_done && op_kind == erx_pkg::ERX_OP_UNLOCK && pwd_mismatch
        |=> st_r.perr && st_r.prot)
        else $error("unlock mismatch unflagged");

    // nv update flags the portion that failed
    chk_nv_update: assert property ( // see [R12]
        op_done && op_kind == erx_pkg::ERX_OP_NV_REG
        |=> (st_r.eerr || !$past(fail_ers)) && (st_r.perr || !$past(fail_pgm)))
        else $error("nv update failure unflagged");

    // protected status write
    chk_stat_wr_prot: assert property ( // see [R13]
        op_done && op_kind == erx_pkg::ERX_OP_STAT_WR && swp_active
        |=> st_r.eerr && st_r.prot)
        else $error("status write unflagged");

    // erase of a protected target
    chk_erase_prot: assert property ( // see [R14] [R5]
        op_done && op_kind == erx_pkg::ERX_OP_ERASE && target_prot
        |=> st_r.eerr && st_r.prot)
        else $error("protected erase unflagged");

    // failed sector/block/info/persistent erase or chip erase
    chk_erase_fail: assert property ( // see [R7] [R14]
        op_done && fail_ers
        && (op_kind == erx_pkg::ERX_OP_ERASE || op_kind == erx_pkg::ERX_OP_CHIP_ERS)
        |=> st_r.eerr)
        else $error("erase failure unflagged");

    // chip erase over a block-protected block
    chk_chip_bp_flags: assert property ( // see [R15]
        op_done && op_kind == erx_pkg::ERX_OP_CHIP_ERS && bp_covered
        |=> st_r.eerr && st_r.prot)
        else $error("guarded chip erase unflagged");

    // sector lock bits alone leave chip erase clean
    chk_chip_lock_only: assert property ( // see [R15]
        op_done && op_kind == erx_pkg::ERX_OP_CHIP_ERS && !bp_covered && !fail_ers
        && !st_r.eerr && !st_r.prot
        |=> !st_r.eerr && !st_r.prot)
        else $error("chip erase flagged wrongly");

    // failed function register write
    chk_func_wr_fail: assert property ( // see [R20]
        op_done && op_kind == erx_pkg::ERX_OP_FUNC_WR && fail_pgm
        |=> st_r.perr)
        else $error("function write failure unflagged");
endmodule

// File: tb/erx_host_model.sv
// host-side partner: issues register commands and operation outcomes
`timescale 1ns/1ps
module erx_host_model (
    input  wire logic        clock,
    output logic             soft_reset,
    output logic             cmd_valid,
    output logic [7:0]       cmd_opcode,
    output logic [7:0]       cmd_data,
    output logic             op_done,
    output erx_pkg::erx_op_t op_kind,
    output logic [9:0]       qual
);
    // idle at time zero, nothing requested
    initial
    begin
        soft_reset = 1'b0;
        cmd_valid  = 1'b0;
        cmd_opcode = 8'h00;
        cmd_data   = 8'h00;
        op_done    = 1'b0;
        op_kind    = erx_pkg::ERX_OP_NONE;
        qual       = 10'h000;
    end

    // one command held across exactly one rising edge
    task automatic cmd(input logic [7:0] opc, input logic [7:0] dat);
        @(negedge clock);
        cmd_valid  = 1'b1;
        cmd_opcode = opc;
        cmd_data   = dat;
        @(negedge clock);
        cmd_valid  = 1'b0;
        // released bytes flip so a stale value is never mistaken for a command
        cmd_opcode = ~opc;
        cmd_data   = ~dat;
    endtask

    // an operation terminating with its qualifiers
    task automatic op(input erx_pkg::erx_op_t k, input logic [9:0] q);
        @(negedge clock);
        op_done = 1'b1;
        op_kind = k;
        qual    = q;
        @(negedge clock);
        op_done = 1'b0;
        qual    = ~q;
    endtask

    // software reset pulse, one cycle wide
    task automatic sreset;
        @(negedge clock);
        soft_reset = 1'b1;
        @(negedge clock);
        soft_reset = 1'b0;
    endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the extended read register core
`timescale 1ns/1ps
module testbench;
    logic             clock;      // 10 MHz
    logic             rstn;       // hardware reset, active low
    logic             nv_done;    // acknowledgement only, tied low
    logic             soft_reset, cmd_valid, op_done;
    logic [7:0]       cmd_opcode, cmd_data, reg_rdata, nv_image;
    erx_pkg::erx_op_t op_kind;
    logic [9:0]       qual;       // packed qualifiers from the host
    logic             tp, ts, bp, fp, fe, mc, pm, sw;
    logic [1:0]       mb;
    logic             nv_write_req, drive_reserved, lpe;
    logic [2:0]       drive_strength;
    int               mismatches = 0;
    int               checks = 0;
    int               cycles = 0;

    assign {tp, ts, bp, fp, fe, mc, mb, pm, sw} = qual;

    erx_host_model host (.clock(clock), .soft_reset(soft_reset), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_data(cmd_data), .op_done(op_done),
        .op_kind(op_kind), .qual(qual));

    erx_core uut (.clock(clock), .rstn(rstn), .soft_reset(soft_reset),
        .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_data(cmd_data),
        .nv_done(nv_done), .op_done(op_done), .op_kind(op_kind), .target_prot(tp),
        .target_susp(ts), .bp_covered(bp), .fail_pgm(fp), .fail_ers(fe),
        .mode_chosen(mc), .mode_bits(mb), .pwd_mismatch(pm), .swp_active(sw),
        .reg_rdata(reg_rdata), .nv_image(nv_image), .nv_write_req(nv_write_req),
        .drive_strength(drive_strength), .drive_reserved(drive_reserved),
        .learning_pattern_enable(lpe));

    // free-running clock, 100 ns period
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // hang guard: the sequence needs well under this many cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            end_sim;
        end
    end

    // single compare for every byte-wide result
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic end_sim;
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // default image straight after reset
    task automatic t_reset;
        cmp(reg_rdata, 8'he0, "reset image");
        cmp({5'h00, drive_strength}, {5'h00, erx_pkg::ERX_DS_DEFAULT}, "reset ds");
        cmp({7'h00, nv_write_req}, 8'h00, "idle nv req");
    endtask

    // volatile set: low nibble ignored, every drive code decoded
    task automatic t_volatile;
        host.cmd(erx_pkg::ERX_OP_SET_V, 8'h3f);
        cmp(reg_rdata, 8'h30, "volatile set");
        cmp({7'h00, lpe}, 8'h01, "pattern enable");
        cmp(nv_image, 8'he0, "nv untouched");
        // an opcode outside the three leaves the register alone
        host.cmd(8'h84, 8'h00);
        cmp(reg_rdata, 8'h30, "foreign opcode");
        for (int c = 0; c < 8; c++)
        begin
            host.cmd(erx_pkg::ERX_OP_SET_V, {c[2:0], 5'h1f});
            cmp({5'h00, drive_strength}, {5'h00, c[2:0]}, "ds code");
            cmp({7'h00, drive_reserved}, {7'h00, c == 0 || c == 4}, "reserved");
        end
    endtask

    // non-volatile set: image stored and one program request
    task automatic t_nonvol;
        host.cmd(erx_pkg::ERX_OP_SET_NV, 8'ha5);
        cmp({7'h00, nv_write_req}, 8'h01, "nv req");
        cmp(nv_image, 8'ha0, "nv image");
        @(negedge clock);
        cmp({7'h00, nv_write_req}, 8'h00, "nv req one cycle");
    endtask

    // one outcome, expected flags, then the clear command
    task automatic flag_case(input erx_pkg::erx_op_t k, input logic [9:0] q,
                             input logic [2:0] e);
        host.op(k, q);
        cmp({4'h0, reg_rdata[3:0]}, {4'h0, e, 1'b0}, "flags set");
        host.cmd(erx_pkg::ERX_OP_CLEAR, 8'h00);
        cmp({4'h0, reg_rdata[3:0]}, 8'h00, "flags cleared");
    endtask

    // every operation class with one or more failing outcomes, clean ones for program, mode lock program and chip erase
    task automatic t_flags;
        flag_case(erx_pkg::ERX_OP_PROGRAM, 10'h208, 3'h3);
        flag_case(erx_pkg::ERX_OP_PROGRAM, 10'h108, 3'h3);
        flag_case(erx_pkg::ERX_OP_PROGRAM, 10'h048, 3'h2);
        flag_case(erx_pkg::ERX_OP_PROGRAM, 10'h008, 3'h0);
        flag_case(erx_pkg::ERX_OP_INFO_PGM, 10'h208, 3'h3);
        flag_case(erx_pkg::ERX_OP_MODE_PGM, 10'h018, 3'h3);
        flag_case(erx_pkg::ERX_OP_MODE_PGM, 10'h000, 3'h3);
        flag_case(erx_pkg::ERX_OP_MODE_PGM, 10'h008, 3'h0);
        flag_case(erx_pkg::ERX_OP_UNLOCK, 10'h00a, 3'h3);
        flag_case(erx_pkg::ERX_OP_NV_REG, 10'h028, 3'h4);
        flag_case(erx_pkg::ERX_OP_NV_REG, 10'h048, 3'h2);
        flag_case(erx_pkg::ERX_OP_STAT_WR, 10'h009, 3'h5);
        flag_case(erx_pkg::ERX_OP_ERASE, 10'h028, 3'h4);
        flag_case(erx_pkg::ERX_OP_ERASE, 10'h208, 3'h5);
        flag_case(erx_pkg::ERX_OP_CHIP_ERS, 10'h088, 3'h5);
        flag_case(erx_pkg::ERX_OP_CHIP_ERS, 10'h208, 3'h0);
        flag_case(erx_pkg::ERX_OP_FUNC_WR, 10'h048, 3'h2);
    endtask

    // flags accumulate, survive commands, fall to both resets
    task automatic t_sticky;
        host.op(erx_pkg::ERX_OP_ERASE, 10'h028);
        host.op(erx_pkg::ERX_OP_PROGRAM, 10'h048);
        host.cmd(erx_pkg::ERX_OP_SET_V, 8'h5f);
        repeat (4) @(negedge clock);
        cmp(reg_rdata, 8'h5c, "sticky with set");
        host.sreset;
        cmp(reg_rdata, 8'ha0, "soft reset");
        // a failure and a clear in the same cycle: the failure must survive
        fork
            host.op(erx_pkg::ERX_OP_FUNC_WR, 10'h048);
            host.cmd(erx_pkg::ERX_OP_CLEAR, 8'h00);
        join
        cmp(reg_rdata, 8'ha4, "set beats clear");
        host.op(erx_pkg::ERX_OP_UNLOCK, 10'h00a);
        @(negedge clock);
        rstn = 1'b0;
        @(negedge clock);
        cmp(reg_rdata, 8'he0, "hard reset");
        rstn = 1'b1;
        @(negedge clock);
        cmp(reg_rdata, 8'he0, "after reset");
    endtask

    // main sequence
    initial
    begin
        rstn = 1'b0;
        nv_done = 1'b0;
        repeat (16) @(negedge clock);
        rstn = 1'b1;
        t_reset;
        t_volatile;
        t_nonvol;
        t_flags;
        t_sticky;
        end_sim;
    end
endmodule
